// >>> bench/beat_engine_model.sv
`timescale 1ns/1ps
// stand-in for the beat engine: a beat every PERIOD cycles while audio flows
module beat_engine_model #(
   parameter PERIOD = 16
) (
   // clock and bench controls
   input  wire sys_clk,
   input  wire rst,
   input  wire audio_on,
   input  wire lock_on,
   // toward the sampler
   output reg  beat_pulse = 1'b0,
   output reg  engine_locked = 1'b0,
   output reg  audio_present = 1'b0
);
   integer cnt_q = 0; // cycles since the last beat
   ////////////////////////////////////////////////////////////////////////////////
   // no audio means no beats, so a recording stalls just as on the real panel
   always @(posedge sys_clk) begin
      if (rst || !audio_on) begin
         cnt_q <= 0;
         beat_pulse <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
         beat_pulse <= (cnt_q == PERIOD - 1);
      end
      engine_locked <= lock_on;
      audio_present <= audio_on;
   end
endmodule // beat_engine_model

// >>> bench/loop_sampler_ctl_props.sv
`timescale 1ns/1ps
`include "sampler_ctl_defs.vh"
module loop_sampler_ctl_props #(parameter CLEAR_CYC = 50, FLASH_CYC = 20, BLINK_CYC = 4) (
   // clock, reset, enable
   input wire        sys_clk,
   input wire        rst,
   input wire        ce,
   // bus
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [3:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire        wb_ack_o,
   // watched outputs
   input wire [1:0]  pad_led,
   input wire [1:0]  pad_play,
   input wire [1:0]  pad_rec,
   input wire [5:0]  rec_beats,
   input wire        src_cue,
   input wire [1:0]  tempo_range,
   input wire        tempo_clear,
   input wire        tap_tempo_set
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // a request is taken only with no ack pending; ce low would freeze the slave
   wire take = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
   ////////////////////////////////////////////////////////////////////////////////
   chk_ack_next: assert property (take |=> wb_ack_o)
      else $error("bus request not answered in the next cycle");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for two cycles");
   chk_cue_write: assert property (
      take && wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL
      |=> src_cue == $past(wb_dat_i[`CTRL_SRC_BIT])) else $error("source select not written");
   chk_rec_single: assert property (pad_rec != 2'b11)
      else $error("two pads recording");
   chk_other_dark: assert property (
      pad_rec != 2'b00 && pad_rec == $past(pad_rec) |-> (pad_led & ~pad_rec) == 2'b00)
      else $error("idle pad lit during recording");
   chk_beats_max: assert property (rec_beats <= `MAX_BEATS)
      else $error("beat count beyond maximum");
   chk_auto_play: assert property ($fell(pad_rec[0]) |-> ##[0:2] pad_play[0])
      else $error("pad not playing after recording");
   chk_old_loop: assert property (
      pad_rec[1] && $past(pad_rec[1]) && $past(pad_play[1]) |-> pad_play[1])
      else $error("old loop stopped during overwrite");
   chk_range_boot: assert property ($fell(rst) |-> tempo_range == `RANGE_RESET)
      else $error("range not default after reset");
   chk_range_legal: assert property (tempo_range != 2'h3)
      else $error("illegal tempo range");
   chk_pulse_once: assert property (
      tempo_clear || tap_tempo_set |=> !tempo_clear && !tap_tempo_set)
      else $error("tempo pulse longer than one cycle");
endmodule // loop_sampler_ctl_props
bind loop_sampler_ctl loop_sampler_ctl_props #(.CLEAR_CYC(CLEAR_CYC), .FLASH_CYC(FLASH_CYC),
   .BLINK_CYC(BLINK_CYC)) props_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .pad_led(pad_led),
   .pad_play(pad_play), .pad_rec(pad_rec), .rec_beats(rec_beats), .src_cue(src_cue),
   .tempo_range(tempo_range), .tempo_clear(tempo_clear), .tap_tempo_set(tap_tempo_set));

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "sampler_ctl_defs.vh"
module tb;
   // bench-driven inputs
   reg         sys_clk = 1'b0;
   reg         rst = 1'b1;
   reg         ce = 1'b1;
   reg         wb_cyc_i = 1'b0;
   reg         wb_stb_i = 1'b0;
   reg         wb_we_i = 1'b0;
   reg  [3:0]  wb_adr_i = 4'h0;
   reg  [3:0]  wb_sel_i = 4'hf;
   reg  [31:0] wb_dat_i = 32'h0;
   reg  [1:0]  pad_button = 2'h0;
   reg         tap_clear_button = 1'b0;
   reg         pad_overwrite_button = 1'b0;
   reg  [1:0]  mode_switch = 2'h0;
   reg  [1:0]  fader_open = 2'h0;
   reg  [1:0]  foot_switch = 2'h0;
   reg         audio_on = 1'b0;
   reg         lock_on = 1'b0;
   // design outputs
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, beat_pulse, engine_locked, audio_present, tempo_lock_indicator;
   wire        tap_clear_led, src_cue, tempo_clear, tap_tempo_set;
   wire [1:0]  pad_led, pad_play, pad_reverse, pad_restart, pad_rec, tempo_range, foot_press;
   wire [5:0]  rec_beats;
   // reference state and score
   integer     n_errors = 0;
   integer     total_checks = 0;
   integer     n_tap = 0;
   integer     n_clr = 0;
   integer     n_rst = 0;
   integer     i, c;
   reg  [31:0] q, d;
   ////////////////////////////////////////////////////////////////////////////////
   loop_sampler_ctl #(.CLEAR_CYC(50), .FLASH_CYC(20), .BLINK_CYC(4)) uut (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_button(pad_button),
      .tap_clear_button(tap_clear_button), .pad_overwrite_button(pad_overwrite_button),
      .mode_switch(mode_switch), .fader_open(fader_open), .foot_switch(foot_switch),
      .beat_pulse(beat_pulse), .engine_locked(engine_locked), .audio_present(audio_present),
      .pad_led(pad_led), .tempo_lock_indicator(tempo_lock_indicator),
      .tap_clear_led(tap_clear_led), .pad_play(pad_play), .pad_reverse(pad_reverse),
      .pad_restart(pad_restart), .pad_rec(pad_rec), .rec_beats(rec_beats), .src_cue(src_cue),
      .tempo_range(tempo_range), .tempo_clear(tempo_clear), .tap_tempo_set(tap_tempo_set),
      .foot_press(foot_press));
   beat_engine_model #(.PERIOD(16)) engine (.sys_clk(sys_clk), .rst(rst), .audio_on(audio_on),
      .lock_on(lock_on), .beat_pulse(beat_pulse), .engine_locked(engine_locked),
      .audio_present(audio_present));
   ////////////////////////////////////////////////////////////////////////////////
   // one-cycle pulses are counted at every edge so none slips past a check
   always @(posedge sys_clk) begin
      n_tap <= n_tap + (tap_tempo_set === 1'b1);
      n_clr <= n_clr + (tempo_clear === 1'b1);
      n_rst <= n_rst + (pad_restart[0] === 1'b1);
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   // classic cycle: hold everything until ack is sampled, then release for a cycle
   task wb(input w, input [3:0] a, input [31:0] dw, output [31:0] dr);
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= dw;
         @(posedge sys_clk);
         // only the watchdog ends a wait for the answer
         while (wb_ack_o !== 1'b1)
            @(posedge sys_clk);
         dr = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   // press buttons for n cycles, then leave room for the two-stage synchroniser
   task push(input [1:0] p, input tp, input integer n);
      begin
         pad_button <= p;
         tap_clear_button <= tp;
         tick(n);
         pad_button <= 2'h0;
         tap_clear_button <= 1'b0;
         tick(6);
      end
   endtask
   // counts high cycles of lock indicator (0) or a pad led (1, 2)
   task hi(input integer n, input integer b, output integer cnt);
      reg [2:0] v;
      begin
         cnt = 0;
         repeat (n) begin
            @(posedge sys_clk);
            v = {pad_led, tempo_lock_indicator};
            cnt = cnt + v[b];
         end
      end
   endtask
   // waits for every recording to end; a hang is left to the watchdog
   task rec_done;
      begin
         while (pad_rec !== 2'b00)
            tick(1);
         tick(3);
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d errors %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // watchdog: the sequence needs about 1200 cycles
   initial begin
      tick(30000);
      n_errors = n_errors + 1;
      stop_test;
   end
   initial begin
      d = $urandom(32'hbbd0);
      tick(8);
      rst <= 1'b0;
      tick(1);
      chk({pad_led, pad_play, pad_rec, tempo_range}, 8'h01);
      for (i = 0; i < 4; i = i + 1) begin
         d = $urandom & 32'h1;
         wb(1'b1, 4'h0, d, q);
         chk(src_cue, d[0]);
      end
      wb_sel_i <= 4'he;
      wb(1'b1, 4'h0, {31'h0, ~d[0]}, q);
      chk(src_cue, d[0]);
      wb_sel_i <= 4'hf;
      wb(1'b0, 4'hc, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, 4'h0, 32'h2, q);
      tick(3);
      chk({tempo_lock_indicator, tap_clear_led}, 2'b01);
      wb(1'b1, 4'h0, 32'h0, q);
      audio_on <= 1'b1;
      hi(40, 0, c);
      chk(c > 0 && c < 40, 1);
      hi(40, 1, c);
      chk(c > 0 && c < 40, 1);
      lock_on <= 1'b1;
      tick(4);
      hi(20, 0, c);
      chk(c, 20);
      for (i = 0; i < 3; i = i + 1) begin
         chk(n_tap, 0);
         push(2'h0, 1'b1, 5);
         tick(9);
      end
      chk(n_tap, 1);
      wb(1'b0, 4'h8, 32'h0, q);
      chk(q[16], 1'b1);
      push(2'h0, 1'b1, 55);
      chk(n_clr, 1);
      hi(20, 0, c);
      chk(c > 0 && c < 20, 1);
      wb(1'b0, 4'h8, 32'h0, q);
      chk(q[16], 1'b0);
      tap_clear_button <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
         tick(5);
         mode_switch <= 2 - i;
         tick(6);
         chk(tempo_range, 2 - i);
      end
      push(2'h0, 1'b0, 1);
      chk(n_clr, 1);
      wb(1'b0, 4'h4, 32'h0, q);
      chk(q[1:0], 2'h0);
      push(2'b01, 1'b0, 4);
      tick(16);
      chk(pad_rec, 2'b01);
      // clock enable low must freeze the beat count although beats go on
      d = rec_beats;
      ce <= 1'b0;
      tick(40);
      chk(rec_beats, d);
      ce <= 1'b1;
      hi(40, 2, c);
      chk(c, 0);
      hi(48, 1, c);
      chk(c > 0 && c < 48, 1);
      rec_done;
      chk({rec_beats, pad_play, pad_led[0]}, {6'h20, 2'b01, 1'b1});
      push(2'b01, 1'b0, 4);
      chk({pad_play[0], pad_led[0]}, 2'b00);
      push(2'b01, 1'b0, 4);
      chk({pad_play[0], pad_led[0]}, 2'b11);
      push(2'b10, 1'b0, 4);
      tick(30);
      push(2'b10, 1'b0, 4);
      rec_done;
      chk(rec_beats[0] == 1'b0 && rec_beats != 6'h0 && pad_play[1] == 1'b1, 1);
      mode_switch <= `MODE_SHOT;
      tick(6);
      chk(pad_play, 2'b11);
      push(2'b01, 1'b0, 4);
      chk(pad_play[0], 1'b0);
      i = n_rst;
      pad_button <= 2'b01;
      tick(40);
      chk(pad_play[0], 1'b1);
      chk(n_rst - i, 1);
      push(2'h0, 1'b0, 1);
      chk(pad_play[0], 1'b0);
      fader_open <= 2'b01;
      tick(40);
      chk(pad_play[0], 1'b1);
      fader_open <= 2'b00;
      mode_switch <= `MODE_REV;
      tick(6);
      push(2'b10, 1'b0, 4);
      push(2'b10, 1'b0, 2);
      chk({pad_play[1], pad_reverse[1]}, 2'b11);
      mode_switch <= `MODE_LOOP;
      pad_overwrite_button <= 1'b1;
      push(2'h0, 1'b0, 4);
      pad_overwrite_button <= 1'b0;
      push(2'b10, 1'b0, 4);
      tick(16);
      chk({pad_rec[1], pad_play[1]}, 2'b11);
      foot_switch <= 2'b10;
      rst <= 1'b1;
      tick(8);
      rst <= 1'b0;
      tick(1);
      chk({pad_play, pad_rec, tempo_range}, 6'h01);
      tick(12);
      foot_switch <= 2'b01;
      tick(6);
      chk(foot_press, 2'b11);
      foot_switch <= 2'b10;
      tick(6);
      chk(foot_press, 2'b00);
      stop_test;
   end
endmodule // tb

// >>> core/loop_sampler_ctl.v
// Notes on behaviour
// - overwrite keeps old loop playing until done
// - loop, single-shot, reverse modes by switch
// - tempo adopted after three taps, immediately
// - long tap-clear hold clears tempo, keeps samples
// - lock indicator flashes briefly after clear
// - lock indicator flashes searching, steady locked
// - disengaged: lock off, clear indicator lit
// - single-shot fader open triggers and loops
// - auto play after record; button toggles mute
// - foot switch polarity sensed after reset
// - tap-clear plus mode switch picks range
// - left 60-120, middle 90-180 default
// - range returns to default on reset
// - one recording at a time; empty at boot
// - empty pads flash when source has audio
// - recording pad flashes per beat, other off
// - second press ends at 1 or even; 32 max
// - playing lit steady, muted off, toggles
// - loop boundaries snapped to beat grid
// - mode latched per pad at start
// - single-shot plays while held, restarts
// - source select master or cue mix
// - reverse starts on single press
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "sampler_ctl_defs.vh"
module loop_sampler_ctl #(
   parameter CLEAR_CYC = (`CLEAR_HOLD_MS * `CLK_MHZ * 1000),
   parameter FLASH_CYC = (`ACK_FLASH_MS * `CLK_MHZ * 1000),
   parameter BLINK_CYC = (`BLINK_MS * `CLK_MHZ * 1000)
) (
   // clock, reset, enable
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        ce,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // front panel (asynchronous)
   input  wire [1:0]  pad_button,
   input  wire        tap_clear_button,
   input  wire        pad_overwrite_button,
   input  wire [1:0]  mode_switch,
   input  wire [1:0]  fader_open,
   input  wire [1:0]  foot_switch,
   // beat engine (same clock)
   input  wire        beat_pulse,
   input  wire        engine_locked,
   input  wire        audio_present,
   // indicators and controls
   output reg  [1:0]  pad_led,
   output reg         tempo_lock_indicator,
   output reg         tap_clear_led,
   output reg  [1:0]  pad_play,
   output reg  [1:0]  pad_reverse,
   output reg  [1:0]  pad_restart,
   output reg  [1:0]  pad_rec,
   output reg  [5:0]  rec_beats,
   output reg         src_cue,
   output reg  [1:0]  tempo_range,
   output reg         tempo_clear,
   output reg         tap_tempo_set,
   output reg  [1:0]  foot_press
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers: first stage only feeds second stage
reg [11:0] sync1_q;
reg [11:0] sync2_q;
reg [11:0] prev_q;
wire [11:0] raw = {foot_switch, fader_open, mode_switch, pad_overwrite_button,
                   tap_clear_button, pad_button, 2'h0};
always @(posedge sys_clk) begin
   if (rst) begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
      prev_q  <= 12'h000;
   end else if (ce) begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
   end
end
wire [1:0] btn      = sync2_q[3:2];
wire [1:0] btn_rise = sync2_q[3:2] & ~prev_q[3:2];
wire [1:0] btn_fall = ~sync2_q[3:2] & prev_q[3:2];
wire       tap      = sync2_q[4];
wire       tap_rise = sync2_q[4] & ~prev_q[4];
wire       ovw_rise = sync2_q[5] & ~prev_q[5];
wire [1:0] msw      = sync2_q[7:6];
wire [1:0] msw_prev = prev_q[7:6];
wire [1:0] fad_rise = sync2_q[9:8] & ~prev_q[9:8];
wire [1:0] fad      = sync2_q[9:8];
wire [1:0] foot     = sync2_q[11:10];

////////////////////////////////////////////////////////////////////////////////
// foot switch polarity caught on the fourth cycle after reset release
reg       pol_done_q;
reg [1:0] foot_pol_q;           // resting level of each foot switch
reg [2:0] settle_q;             // waits for synchroniser to fill
always @(posedge sys_clk) begin
   if (rst) begin
      pol_done_q <= 1'b0;
      foot_pol_q <= 2'h0;
      settle_q   <= 3'h0;
      foot_press <= 2'h0;
   end else if (ce) begin
      if (!pol_done_q) begin
         settle_q <= settle_q + 3'h1;
         if (settle_q == 3'h3) begin
            foot_pol_q <= foot;
            pol_done_q <= 1'b1;
         end
      end
      // pressed means away from the sensed rest level
      foot_press <= pol_done_q ? (foot ^ foot_pol_q) : 2'h0;
   end
end
// foot presses act like pad presses
reg  [1:0] prev_foot_q;
wire [1:0] foot_rise = foot_press & ~(prev_foot_q);
always @(posedge sys_clk) begin
   if (rst) prev_foot_q <= 2'h0;
   else if (ce) prev_foot_q <= foot_press;
end
wire [1:0] press = btn_rise | foot_rise;

////////////////////////////////////////////////////////////////////////////////
// wishbone registers: ctrl (source, engine), status, tempo
reg        eng_off_q;            // tempo tracking disengaged
reg        ack_d;
reg [1:0]  stored_q;             // pad holds a recording
reg [15:0] tap_per_q;            // gap before the latest tap
reg        tempo_valid_q;        // a tempo is memorised
always @(posedge sys_clk) begin
   if (rst) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      src_cue   <= 1'b0;
      eng_off_q <= 1'b0;
   end else if (ce) begin
      wb_ack_o <= ack_d;
      if (ack_d && wb_we_i && wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
         src_cue   <= wb_dat_i[`CTRL_SRC_BIT];
         eng_off_q <= wb_dat_i[`CTRL_ENG_BIT];
      end
      if (ack_d && !wb_we_i) begin
         case (wb_adr_i)
            `REG_CTRL:   wb_dat_o <= {30'h0, eng_off_q, src_cue};
            `REG_STATUS: wb_dat_o <= {16'h0, 2'h0, rec_beats, pad_play,
                                      pad_rec, stored_q, tempo_range};
            `REG_TEMPO:  wb_dat_o <= {15'h0, tempo_valid_q, tap_per_q};
            default:     wb_dat_o <= 32'h00000000;  // unmapped reads zero
         endcase
      end
   end
end
always @* ack_d = wb_cyc_i & wb_stb_i & ~wb_ack_o;

////////////////////////////////////////////////////////////////////////////////
// tempo range, tap tempo, clear hold
reg [31:0] hold_cnt_q;
reg [31:0] flash_cnt_q;
reg        cleared_q;            // clear already done for this hold
reg [15:0] tap_gap_q;            // clock cycles between taps (saturating)
reg [2:0]  tap_cnt_q;
reg        lock_seen_q;          // engine lock level last cycle
reg        range_used_q;         // tap hold used for range select
always @(posedge sys_clk) begin
   if (rst) begin
      tempo_range   <= `RANGE_RESET;
      hold_cnt_q    <= 32'h0;
      flash_cnt_q   <= 32'h0;
      cleared_q     <= 1'b0;
      tap_gap_q     <= 16'h0;
      tap_per_q     <= 16'h0;
      tap_cnt_q     <= 3'h0;
      tempo_valid_q <= 1'b0;
      tempo_clear   <= 1'b0;
      tap_tempo_set <= 1'b0;
      range_used_q  <= 1'b0;
      lock_seen_q   <= 1'b0;
   end else if (ce) begin
      tempo_clear   <= 1'b0;
      tap_tempo_set <= 1'b0;
      lock_seen_q   <= engine_locked;
      if (tap_gap_q != 16'hffff) tap_gap_q <= tap_gap_q + 16'h1;
      if (flash_cnt_q != 32'h0) flash_cnt_q <= flash_cnt_q - 32'h1;
      // range select while tap held and mode switch moved
      if (tap && msw != msw_prev) begin
         range_used_q <= 1'b1;
         case (msw)
            `MODE_LOOP: tempo_range <= `RANGE_LOW;
            `MODE_SHOT: tempo_range <= `RANGE_MID;
            `MODE_REV:  tempo_range <= `RANGE_HIGH;
            default:    tempo_range <= tempo_range;
         endcase
      end
      if (tap) begin
         hold_cnt_q <= hold_cnt_q + 32'h1;
         if (hold_cnt_q == CLEAR_CYC - 1 && !range_used_q && !cleared_q) begin
            cleared_q     <= 1'b1;
            tempo_clear   <= 1'b1;
            tap_cnt_q     <= 3'h0;
            tempo_valid_q <= 1'b0;
            flash_cnt_q   <= FLASH_CYC;
         end
      end else begin
         hold_cnt_q   <= 32'h0;
         cleared_q    <= 1'b0;
         range_used_q <= 1'b0;
      end
      // a fresh lock memorises the tempo; placed after the clear so a set wins
      if (engine_locked && !lock_seen_q) tempo_valid_q <= 1'b1;
      // tap counting: taps spaced more than the gap limit restart the count
      if (tap_rise) begin
         tap_gap_q <= 16'h0;
         tap_per_q <= tap_gap_q;
         if (tap_gap_q == 16'hffff) tap_cnt_q <= 3'h1;
         else if (tap_cnt_q < `TAPS_NEEDED) tap_cnt_q <= tap_cnt_q + 3'h1;
         if (tap_cnt_q + 3'h1 >= `TAPS_NEEDED && tap_gap_q != 16'hffff) begin
            tap_tempo_set <= 1'b1;
            tempo_valid_q <= 1'b1;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// blink generator for indicators
reg [31:0] blink_cnt_q;
reg        blink_q;
always @(posedge sys_clk) begin
   if (rst) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
   end else if (ce) begin
      if (blink_cnt_q >= BLINK_CYC - 1) begin
         blink_cnt_q <= 32'h0;
         blink_q     <= ~blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// pad recording and playback state
localparam S_EMPTY = 2'h0;
localparam S_REC   = 2'h1;
localparam S_PLAY  = 2'h2;
localparam S_MUTE  = 2'h3;
reg [1:0] st_q [0:1];
reg [1:0] mode_q [0:1];          // mode latched when the pad starts
reg       arm_q;                 // overwrite armed
reg       stop_req_q;            // stop at next legal beat
reg       rec_pad_q;
reg       old_play_q;            // old loop still playing under overwrite
wire      recording = (st_q[0] == S_REC) | (st_q[1] == S_REC);
// pad 0 wins when both pads would start a recording in the same cycle
wire      start0    = press[0] & ((st_q[0] == S_EMPTY) | (arm_q & (st_q[0] != S_REC)));
wire [1:0] start_block = {start0, 1'b0};

function legal_len;              // 1 or even beat counts
   input [5:0] n;
   begin
      legal_len = (n == 6'h1) | ~n[0];
   end
endfunction

integer i;
always @(posedge sys_clk) begin
   if (rst) begin
      for (i = 0; i < 2; i = i + 1) begin
         st_q[i]   <= S_EMPTY;
         mode_q[i] <= `MODE_LOOP;
      end
      stored_q    <= 2'h0;
      arm_q       <= 1'b0;
      stop_req_q  <= 1'b0;
      rec_pad_q   <= 1'b0;
      old_play_q  <= 1'b0;
      rec_beats   <= 6'h0;
      pad_play    <= 2'h0;
      pad_reverse <= 2'h0;
      pad_restart <= 2'h0;
      pad_rec     <= 2'h0;
   end else if (ce) begin
      pad_restart <= 2'h0;
      for (i = 0; i < 2; i = i + 1) begin
         case (st_q[i])
            S_EMPTY: begin
               if (press[i] && !recording && !start_block[i]) begin
                  st_q[i]    <= S_REC;
                  rec_pad_q  <= i[0];
                  rec_beats  <= 6'h0;
                  stop_req_q <= 1'b0;
                  old_play_q <= 1'b0;
                  arm_q      <= 1'b0;
               end
            end
            S_REC: begin
               if (press[i]) stop_req_q <= 1'b1;
               // boundaries only move on beats
               if (beat_pulse) begin
                  rec_beats <= rec_beats + 6'h1;
                  if (rec_beats + 6'h1 == `MAX_BEATS ||
                      (stop_req_q && legal_len(rec_beats + 6'h1))) begin
                     st_q[i]     <= S_PLAY;
                     stored_q[i] <= 1'b1;
                     old_play_q  <= 1'b0;
                     mode_q[i]   <= msw;
                     pad_restart[i] <= 1'b1;
                  end
               end
            end
            S_PLAY, S_MUTE: begin
               if (press[i] && arm_q && !recording && !start_block[i]) begin
                  // overwrite: old audio keeps playing meanwhile
                  old_play_q <= (st_q[i] == S_PLAY);
                  st_q[i]    <= S_REC;
                  rec_pad_q  <= i[0];
                  rec_beats  <= 6'h0;
                  stop_req_q <= 1'b0;
                  arm_q      <= 1'b0;
               end else if (st_q[i] == S_MUTE) begin
                  if (press[i] || (msw == `MODE_SHOT && fad_rise[i])) begin
                     st_q[i]   <= S_PLAY;
                     mode_q[i] <= msw;
                     pad_restart[i] <= 1'b1;
                  end
               end else if (mode_q[i] == `MODE_SHOT) begin
                  // held button or open fader keeps looping
                  if (press[i]) pad_restart[i] <= 1'b1;
                  if (!btn[i] && !fad[i] && (btn_fall[i] || !foot_press[i]))
                     st_q[i] <= S_MUTE;
               end else if (press[i]) begin
                  st_q[i] <= S_MUTE;
               end
            end
            default: st_q[i] <= S_EMPTY;
         endcase
         pad_play[i] <= (st_q[i] == S_PLAY) ||
                        (st_q[i] == S_REC && old_play_q);
         pad_reverse[i] <= (mode_q[i] == `MODE_REV);
         pad_rec[i] <= (st_q[i] == S_REC);
      end
      // arming after the clear so a new arming in a start cycle survives
      if (ovw_rise) arm_q <= 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////////////
// indicators
reg beat_flash_q;                // one blink per counted beat
always @(posedge sys_clk) begin
   if (rst) begin
      pad_led              <= 2'h0;
      tempo_lock_indicator <= 1'b0;
      tap_clear_led        <= 1'b0;
      beat_flash_q         <= 1'b0;
   end else if (ce) begin
      if (beat_pulse) beat_flash_q <= 1'b1;
      else if (blink_cnt_q == 32'h0) beat_flash_q <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
         if (recording)
            pad_led[i] <= (st_q[i] == S_REC) ? beat_flash_q : 1'b0;
         else if (st_q[i] == S_EMPTY)
            pad_led[i] <= audio_present & blink_q;
         else
            pad_led[i] <= (st_q[i] == S_PLAY);
      end
      if (eng_off_q) begin
         tempo_lock_indicator <= 1'b0;
         tap_clear_led        <= 1'b1;
      end else begin
         tap_clear_led <= 1'b0;
         if (flash_cnt_q != 32'h0)
            // one on/off flash over the window, unlike the search blink
            tempo_lock_indicator <= (flash_cnt_q > FLASH_CYC / 2);
         else
            tempo_lock_indicator <= engine_locked | blink_q;
      end
   end
end

endmodule // loop_sampler_ctl

// >>> core/sampler_ctl_defs.vh
`ifndef SAMPLER_CTL_DEFS_VH
`define SAMPLER_CTL_DEFS_VH
// register byte addresses
`define REG_CTRL      4'h0
`define REG_STATUS    4'h4
`define REG_TEMPO     4'h8
// ctrl field positions
`define CTRL_SRC_BIT  0
`define CTRL_ENG_BIT  1
// play mode switch codes (left, middle, right)
`define MODE_LOOP     2'h0
`define MODE_SHOT     2'h1
`define MODE_REV      2'h2
// tempo ranges
`define RANGE_LOW     2'h0
`define RANGE_MID     2'h1
`define RANGE_HIGH    2'h2
`define RANGE_RESET   2'h1
// beat limits
`define MAX_BEATS     6'h20
`define TAPS_NEEDED   3'h3
// times
`define CLK_MHZ       100
`define CLEAR_HOLD_MS 1500
`define ACK_FLASH_MS  200
`define BLINK_MS      250
`endif
